// file: shared/bmx_regs.svh
`ifndef BMX_REGS_SVH
`define BMX_REGS_SVH
// Register index and byte address of the mux configuration word
`define BMX_CFG_INDEX 8'h17
`define BMX_CFG_ADDR 10'h05C
// Field positions
`define BMX_POS_ISO_P 21
`define BMX_POS_ISO_N 20
`define BMX_POS_CALP 18
`define BMX_POS_CALN 16
`define BMX_POS_CGM 12
`define BMX_POS_BIST 11
`define BMX_POS_RNOM 8
`define BMX_POS_RMOD 4
`define BMX_POS_RATE 0
// Writable bits and reset value of the 24-bit word
`define BMX_CFG_MASK 24'h3F3F73
`define BMX_CFG_RESET 24'h300040
// Master clock divider exponents, rate codes 00..11
`define BMX_DIV_EXP0 13
`define BMX_DIV_EXP1 15
`define BMX_DIV_EXP2 17
`define BMX_DIV_EXP3 19
`endif

// file: shared/bmx_pkg.sv
package bmx_pkg;
   typedef enum logic [1:0] {
      BMX_CAL_NONE, BMX_CAL_MID, BMX_CAL_VPOS, BMX_CAL_VNEG
   } bmx_cal_type;
   // Analog control bundle driven toward the mux and self-test switches
   typedef struct packed {
      logic pos_input_isolate;
      logic neg_input_isolate;
      bmx_cal_type pos_input_cal_source;
      bmx_cal_type neg_input_cal_source;
      logic [1:0] current_gen_mode;
      logic selftest_active;
      logic drive_isolate_open;
      logic drive_to_sense_close;
      logic lead_bias_200m;
      logic [2:0] selftest_nominal_resistance;
      logic [2:0] selftest_modulated_resistance;
      logic modulation_switches;
   } bmx_ctrl_type;
endpackage

// file: rtl/bmx_mux_config.sv
// Behaviour
// - 24-bit RW config word at 0x17
// - Bit 21 isolates positive input, reset 1
// - Bit 20 isolates negative input, reset 1
// - Bits 19:18 positive calibration source, reset 00
// - Bits 17:16 negative calibration source, reset 00
// - Calibration voltages only when voltage enable set
// - Bits 13:12 current generator mode, reset 00
// - Bit 11 self-test enable, needs voltage enable 0
// - Self-test opens drive, closes drive-sense, 200M
// - Bits 10:8 nominal resistance, reset 000
// - Bits 6:4 modulated resistance, 1xx no modulation
// - Bits 1:0 divide master clock 2^13..2^19
// - Modulation square wave, 50% duty
// - Rate follows master clock tick input; selection input unused
// - Master clock codes give 32768/32000/31968 Hz
`include "bmx_regs.svh"
module bmx_mux_config (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Avalon-MM slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Settings held in other registers, and the master clock tick
   input wire logic cal_voltage_enable_i,
   input wire logic [1:0] master_clock_select_i,
   input wire logic master_clock_tick_i,
   // Analog controls
   output bmx_pkg::bmx_ctrl_type ctrl_o
);
   import bmx_pkg::*;

   logic [23:0] cfg_r;
   logic [23:0] cfg_nxt;
   logic ack_r;
   logic [18:0] div_r;
   logic mod_r;
   logic [4:0] exp_sel;
   logic bist_ok;
   logic hit;

   // One wait state: waitrequest drops the cycle after a request is seen
   assign hit = (avs_address_i == `BMX_CFG_ADDR);

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_r);
      end
   end

   // Handshake shape: exactly one wait state, low for one cycle only
   wait_idle_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low while idle");
   wait_pulse_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   ack_pair_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      ack_r == !avs_waitrequest_o)
      else $error("accept flag and waitrequest disagree");
   req_answer_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o)
      else $error("request not answered after one wait state");

   // Byte-lane merge; unused bits forced to zero
   always_comb begin
      cfg_nxt = cfg_r;
      for (int b = 0; b < 3; b++) begin
         if (avs_byteenable_i[b]) begin
            cfg_nxt[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
         end
      end
      cfg_nxt = cfg_nxt & `BMX_CFG_MASK;
   end

   // Configuration word; write lands on the edge waitrequest is low
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cfg_r <= `BMX_CFG_RESET;
      end else if (avs_write_i && ack_r && hit) begin
         cfg_r <= cfg_nxt;
      end
   end

   // The word only moves on an accepted write to its own address
   wr_unmap_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_write_i && !hit |=> $stable(cfg_r))
      else $error("unmapped write changed config");
   no_wr_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !avs_write_i |=> $stable(cfg_r))
      else $error("config changed without a write");
   wr_once_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_write_i && avs_waitrequest_o |=> $stable(cfg_r))
      else $error("write stored before acceptance");
   lane_zero_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_write_i && ack_r && hit && !avs_byteenable_i[0] |=>
      cfg_r[7:0] == $past(cfg_r[7:0]))
      else $error("disabled lane 0 written");
   lane_one_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_write_i && ack_r && hit && !avs_byteenable_i[1] |=>
      cfg_r[15:8] == $past(cfg_r[15:8]))
      else $error("disabled lane 1 written");
   lane_two_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_write_i && ack_r && hit && !avs_byteenable_i[2] |=>
      cfg_r[23:16] == $past(cfg_r[23:16]))
      else $error("disabled lane 2 written");

   // Read data; unmapped addresses read zero
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && !ack_r) begin
         avs_readdata_o <= hit ? {8'h00, cfg_r} : 32'h0;
      end
   end

   // Read data captured on the first request edge and then held
   rd_data_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_read_i && avs_waitrequest_o && hit |=>
      avs_readdata_o == {8'h00, $past(cfg_r)})
      else $error("read data not the config word");
   rd_unmap_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_read_i && avs_waitrequest_o && !hit |=> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   rd_top_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      avs_readdata_o[31:24] == 8'h00)
      else $error("upper read byte not zero");
   rd_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");

   // Divider exponent per rate code
   always_comb begin
      case (cfg_r[`BMX_POS_RATE +: 2])
         2'b00: exp_sel = 5'(`BMX_DIV_EXP0);
         2'b01: exp_sel = 5'(`BMX_DIV_EXP1);
         2'b10: exp_sel = 5'(`BMX_DIV_EXP2);
         default: exp_sel = 5'(`BMX_DIV_EXP3);
      endcase
   end

   // End codes of the rate table
   exp_low_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      cfg_r[`BMX_POS_RATE +: 2] == 2'b00 |-> exp_sel == 5'(`BMX_DIV_EXP0))
      else $error("rate code 00 wrong divider");
   exp_high_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      cfg_r[`BMX_POS_RATE +: 2] == 2'b11 |-> exp_sel == 5'(`BMX_DIV_EXP3))
      else $error("rate code 11 wrong divider");

   // Counts master clock ticks, so the rate tracks whichever master
   // frequency is selected rather than being fixed.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         div_r <= 19'h0;
      end else if (master_clock_tick_i) begin
         div_r <= div_r + 19'h1;
      end
   end

   // Divider advances on master ticks and on nothing else
   div_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !master_clock_tick_i |=> $stable(div_r))
      else $error("divider moved without a tick");
   div_step_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      master_clock_tick_i |=> div_r == $past(div_r) + 19'h1)
      else $error("divider did not step on a tick");

   // Square wave taken from counter bit exp-1: half period each level
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         mod_r <= 1'b0;
      end else begin
         mod_r <= div_r[exp_sel - 5'h1];
      end
   end

   // Test only meaningful with calibration voltages off
   assign bist_ok = cfg_r[`BMX_POS_BIST] & ~cal_voltage_enable_i;

   // Registered analog controls
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ctrl_o <= '0;
         ctrl_o.pos_input_isolate <= 1'b1;
         ctrl_o.neg_input_isolate <= 1'b1;
      end else begin
         ctrl_o.pos_input_isolate <= cfg_r[`BMX_POS_ISO_P];
         ctrl_o.neg_input_isolate <= cfg_r[`BMX_POS_ISO_N];
         // Voltage choices fall back to none when the enable is off
         ctrl_o.pos_input_cal_source <=
            (cfg_r[`BMX_POS_CALP+1] && !cal_voltage_enable_i) ?
            BMX_CAL_NONE : bmx_cal_type'(cfg_r[`BMX_POS_CALP +: 2]);
         ctrl_o.neg_input_cal_source <=
            (cfg_r[`BMX_POS_CALN+1] && !cal_voltage_enable_i) ?
            BMX_CAL_NONE : bmx_cal_type'(cfg_r[`BMX_POS_CALN +: 2]);
         ctrl_o.current_gen_mode <= cfg_r[`BMX_POS_CGM +: 2];
         ctrl_o.selftest_active <= bist_ok;
         ctrl_o.drive_isolate_open <= bist_ok;
         ctrl_o.drive_to_sense_close <= bist_ok;
         ctrl_o.lead_bias_200m <= bist_ok;
         ctrl_o.selftest_nominal_resistance <= cfg_r[`BMX_POS_RNOM +: 3];
         ctrl_o.selftest_modulated_resistance <= cfg_r[`BMX_POS_RMOD +: 3];
         // Code 1xx leaves all modulation switches open
         ctrl_o.modulation_switches <=
            bist_ok & ~cfg_r[`BMX_POS_RMOD+2] & mod_r;
      end
   end

   // Analog controls are the config fields delayed by one cycle, self-test and cal voltages gated by the voltage enable
   cgm_follow_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      1'b1 |=> ctrl_o.current_gen_mode == $past(cfg_r[`BMX_POS_CGM +: 2]))
      else $error("generator mode not following config");
   rnom_follow_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      1'b1 |=> ctrl_o.selftest_nominal_resistance ==
      $past(cfg_r[`BMX_POS_RNOM +: 3]))
      else $error("nominal resistance not following config");
   rmod_follow_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      1'b1 |=> ctrl_o.selftest_modulated_resistance ==
      $past(cfg_r[`BMX_POS_RMOD +: 3]))
      else $error("modulated resistance not following config");
   bist_off_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !cfg_r[`BMX_POS_BIST] |=> !ctrl_o.selftest_active &&
      !ctrl_o.drive_isolate_open && !ctrl_o.drive_to_sense_close &&
      !ctrl_o.lead_bias_200m)
      else $error("self-test switches set while disabled");
   mod_off_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !cfg_r[`BMX_POS_BIST] |=> !ctrl_o.modulation_switches)
      else $error("modulation while self-test disabled");
   calp_pass_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      cal_voltage_enable_i |=>
      ctrl_o.pos_input_cal_source == $past(cfg_r[`BMX_POS_CALP +: 2]))
      else $error("positive cal source not passed");
   caln_pass_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      cal_voltage_enable_i |=>
      ctrl_o.neg_input_cal_source == $past(cfg_r[`BMX_POS_CALN +: 2]))
      else $error("negative cal source not passed");
   calp_low_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !cfg_r[`BMX_POS_CALP+1] |=>
      ctrl_o.pos_input_cal_source == $past(cfg_r[`BMX_POS_CALP +: 2]))
      else $error("none or mid-supply choice not passed");
   mod_wave_a: assert property (
      @(posedge ref_clk_i) disable iff (!resetn_i)
      cfg_r[`BMX_POS_BIST] && !cal_voltage_enable_i &&
      !cfg_r[`BMX_POS_RMOD+2] |=> ctrl_o.modulation_switches == $past(mod_r))
      else $error("modulation switches not following square wave");

   // Write reaches register on the same edge as acceptance
   wr_update_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (avs_write_i && ack_r && hit && avs_byteenable_i == 4'hF) |=>
      cfg_r == ($past(avs_writedata_i[23:0]) & `BMX_CFG_MASK))
      else $error("config write not stored");
   unused_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (cfg_r & ~`BMX_CFG_MASK) == 24'h0)
      else $error("unused bit set");
   wait_one_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(avs_read_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest not released after one cycle");
   iso_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      ##1 ctrl_o.pos_input_isolate == $past(cfg_r[`BMX_POS_ISO_P]) &&
      ctrl_o.neg_input_isolate == $past(cfg_r[`BMX_POS_ISO_N]))
      else $error("isolate switches not following config");
   cal_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !$past(cal_voltage_enable_i) |->
      !ctrl_o.pos_input_cal_source[1] && !ctrl_o.neg_input_cal_source[1])
      else $error("cal voltage applied while disabled");
   bist_drive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cfg_r[`BMX_POS_BIST] && !cal_voltage_enable_i |=>
      ctrl_o.drive_isolate_open && ctrl_o.drive_to_sense_close &&
      ctrl_o.lead_bias_200m)
      else $error("self-test switches not set");
   bist_block_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cal_voltage_enable_i |=> !ctrl_o.selftest_active)
      else $error("self-test active with cal voltage");
   nomod_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cfg_r[`BMX_POS_RMOD+2] |=> !ctrl_o.modulation_switches)
      else $error("modulation with code 1xx");
   half_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(div_r) && div_r[exp_sel - 5'h1] != mod_r |=>
      mod_r == $past(div_r[exp_sel - 5'h1]))
      else $error("modulation phase not tracking divider");
endmodule // bmx_mux_config

// file: verification/bmx_mux_config_tb_top.sv
module bmx_mux_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bmx_pkg::*;
   logic ref_clk_i = 1'b0, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0;
   logic cal_en = 1'b0, tick = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] be = 4'hF;
   logic [1:0] msel = 2'h0;
   logic waitreq;
   bmx_ctrl_type ctrl;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   localparam logic [9:0] CFG = 10'h05C;
   // Free-running 200 MHz clock
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   bmx_mux_config u_dut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .cal_voltage_enable_i(cal_en), .master_clock_select_i(msel),
      .master_clock_tick_i(tick), .ctrl_o(ctrl)
   );
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [9:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      int k;
      @(posedge ref_clk_i);
      rd <= ~w; wr <= w; addr <= a; wdata <= d; be <= b;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (waitreq !== 1'b0 && k < 50);
      rv = rdata;
      rd <= 1'b0; wr <= 1'b0;
      if (k == 50) n_mismatch++;
   endtask
   task automatic t_regs();
      bus(0, CFG, 0, 4'hF); chk("reset", rv, 32'h300040);
      chk("iso", {ctrl.pos_input_isolate, ctrl.neg_input_isolate}, 2'b11);
      bus(1, CFG, 32'hFFFFFFFF, 4'hF); bus(0, CFG, 0, 4'hF);
      chk("ones", rv, 32'h3F3F73);
      bus(1, CFG, 0, 4'hF); bus(1, CFG, 32'hFFFFFF, 4'h2);
      bus(0, CFG, 0, 4'hF); chk("lane", rv, 32'h003F00);
      bus(1, 10'h060, 32'hFFFFFF, 4'hF); bus(0, 10'h060, 0, 4'hF);
      chk("unmap", rv, 32'h0);
      bus(0, CFG, 0, 4'hF); chk("kept", rv, 32'h003F00);
   endtask
   // Every calibration code with the voltage enable off and on
   task automatic t_cal();
      logic [1:0] e;
      for (int en = 0; en < 2; en++) for (int c = 0; c < 4; c++) begin
         cal_en <= en[0];
         bus(1, CFG, (c << 18) | (c << 16), 4'hF);
         repeat (3) @(posedge ref_clk_i);
         e = (c >= 2 && en == 0) ? 2'h0 : c[1:0];
         chk("calp", ctrl.pos_input_cal_source, e);
         chk("caln", ctrl.neg_input_cal_source, e);
         bus(0, CFG, 0, 4'hF); chk("calrd", rv[19:16], {c[1:0], c[1:0]});
      end
   endtask
   task automatic t_bist();
      cal_en <= 1'b0;
      bus(1, CFG, 32'h302D40, 4'hF); repeat (3) @(posedge ref_clk_i);
      chk("sw", {ctrl.selftest_active, ctrl.drive_isolate_open,
          ctrl.drive_to_sense_close, ctrl.lead_bias_200m}, 4'hF);
      chk("cg", ctrl.current_gen_mode, 2'h2);
      chk("rnom", ctrl.selftest_nominal_resistance, 3'h5);
      chk("rmod", ctrl.selftest_modulated_resistance, 3'h4);
      cal_en <= 1'b1; repeat (3) @(posedge ref_clk_i);
      chk("calblk", ctrl.selftest_active, 1'b0);
      cal_en <= 1'b0; tick <= 1'b1;
      repeat (9000) begin
         @(posedge ref_clk_i);
         if (ctrl.modulation_switches !== 1'b0) chk("nomod", 1, 0);
      end
   endtask
   // Tick held high: one master clock period per cycle
   task automatic t_mod(input logic [1:0] r, input int half, input bit lo);
      int n;
      bus(1, CFG, 32'h300800 | r, 4'hF);
      repeat (3) @(posedge ref_clk_i);
      // Skip a phase cut short by the rate change, then time whole ones
      n = 0;
      while (ctrl.modulation_switches !== 1'b0 && n < 3 * half) begin
         @(posedge ref_clk_i);
         n++;
      end
      n = 0;
      while (ctrl.modulation_switches !== 1'b1 && n < 3 * half) begin
         @(posedge ref_clk_i);
         n++;
      end
      n = 0;
      while (ctrl.modulation_switches === 1'b1 && n < 3 * half) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk("high", n, half);
      if (lo) begin
         n = 0;
         while (ctrl.modulation_switches === 1'b0 && n < 3 * half) begin
            @(posedge ref_clk_i);
            n++;
         end
         chk("low", n, half);
      end
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hang guard sized for the two modulation measurements
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_cal();
      t_bist();
      t_mod(2'h0, 4096, 1'b1);
      msel <= 2'h1;
      t_mod(2'h1, 16384, 1'b0);
      summarize();
   end
endmodule // bmx_mux_config_tb_top
